//--- common/rtc_pkg.sv
// Constants and carrier types for the timekeeping memory block.
// Assumes a 100 MHz system clock and a 15-bit byte address space.
package rtc_pkg;
    // ==========================================================
    // Geometry
    localparam int ADDR_W = 15;
    localparam int MEM_BYTES = 32768;
    localparam logic [10:0] CLK_PAGE = 11'h7FF;
    // ==========================================================
    // Clock register offsets inside the top sixteen bytes
    localparam logic [3:0] OFS_FLAGS = 4'h0;
    localparam logic [3:0] OFS_ALM_SEC = 4'h2;
    localparam logic [3:0] OFS_INTR = 4'h6;
    localparam logic [3:0] OFS_WDOG = 4'h7;
    localparam logic [3:0] OFS_CTRL = 4'h8;
    localparam logic [3:0] OFS_DAY = 4'hC;
    localparam logic [3:0] OFS_DATE = 4'hD;
    localparam logic [3:0] OFS_MONTH = 4'hE;
    localparam logic [3:0] OFS_YEAR = 4'hF;
    // ==========================================================
    // Field positions
    localparam int BIT_WF = 7;
    localparam int BIT_AF = 6;
    localparam int BIT_BAT_LOW = 4;
    localparam int BIT_AE = 7;
    localparam int BIT_ABE = 5;
    localparam int BIT_WDS = 7;
    localparam int BIT_W = 7;
    localparam int BIT_R = 6;
    localparam int BIT_OSC = 7;
    localparam int BIT_AM = 7;
    // Time bits per register, century (offset 8) through year (offset F)
    localparam logic [7:0] TIME_MASK [8] = '{8'h3F, 8'h7F, 8'h7F, 8'h3F,
                                             8'h07, 8'h3F, 8'h1F, 8'hFF};
    // ==========================================================
    // Reset values
    localparam logic [7:0] REG_RST = 8'h00;
    localparam logic [7:0] DATE_RST = 8'h01;
    // ==========================================================
    // Timing
    localparam longint MCLK_HZ = 100_000_000;
    localparam longint POR_HOLD_MS = 40;
    localparam longint POR_HOLD_CYC = (POR_HOLD_MS * MCLK_HZ + 999) / 1000;
    localparam longint WDOG_UNIT_US = 62_500;
    localparam longint WDOG_UNIT_CYC = WDOG_UNIT_US * MCLK_HZ / 1_000_000;
    // ==========================================================
    // Parallel port pins as sampled
    typedef struct packed {
        logic cs_n;
        logic we_n;
        logic oe_n;
        logic [ADDR_W-1:0] addr;
        logic [7:0] data;
    } bus_pins_s;
endpackage

//--- design/nv_timekeeping_sram_rtc.sv
// Byte-wide nonvolatile memory with clock registers in the top 16 bytes.
// Assumes asynchronous host pins and power comparator levels as inputs.
`timescale 1ns/1ps
`default_nettype none
// Contract
// - 32k byte port, clock registers at top
// - Clock registers use ordinary memory cycles
// - BCD century to seconds, 24-hour clock
// - Automatic month lengths and leap days
// - Internal counting set, external visible set
// - Internal set always counts while oscillating
// - User can freeze and resume external copy
// - Alarm match drives interrupt output low
// - Alarm on battery only when enabled
// - Unserviced watchdog fires interrupt or reset
// - Reset held during supply failure
// - Supply out of tolerance deselects device
// - Backup source connected after first power
// - Read drives data only with output enable
// - Write while select and strobe both low
// - Read-only battery-low flag bit
// - Reset held 40 to 200 ms after recovery
module nv_timekeeping_sram_rtc
    import rtc_pkg::*;
#(
    parameter longint SEC_CYC = MCLK_HZ,
    parameter longint POR_CYC = POR_HOLD_CYC,
    parameter longint WD_UNIT_CYC = WDOG_UNIT_CYC
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // Parallel memory port
    input wire logic [ADDR_W-1:0] address_in,
    input wire logic chip_sel_n,
    input wire logic write_en_n,
    input wire logic out_en_n,
    input wire logic [7:0] data_in,
    output logic [7:0] data_out,
    output logic data_oe,
    // Power and battery monitors
    input wire logic above_power_fail_trip_level,
    input wire logic above_battery_switch_level,
    input wire logic battery_exhausted,
    output logic on_battery,
    output logic battery_connected,
    // Open-drain outputs
    output logic alarm_interrupt_out_n,
    output logic alarm_interrupt_oe,
    output logic reset_out_n,
    output logic reset_oe
);
    // ==========================================================
    // Input synchronisers
    localparam int SW = $bits(bus_pins_s) + 3;
    logic [SW-1:0] s1_r, s2_r, s3_r; // Three-stage pipe
    bus_pins_s pin_w, pin2_w, pin3_w;
    logic ok2_w, ok3_w;
    assign pin_w = '{chip_sel_n, write_en_n, out_en_n, address_in, data_in};
    assign pin2_w = s2_r[SW-1 -: $bits(bus_pins_s)];
    assign pin3_w = s3_r[SW-1 -: $bits(bus_pins_s)];
    assign ok2_w = s2_r[2];
    assign ok3_w = s3_r[2];

    // Pipe registers, preset to an idle bus
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            s1_r <= {3'b111, {(SW-3){1'b0}}};
            s2_r <= {3'b111, {(SW-3){1'b0}}};
            s3_r <= {3'b111, {(SW-3){1'b0}}};
        end else begin
            s1_r <= {pin_w, above_power_fail_trip_level,
                     above_battery_switch_level, battery_exhausted};
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // ==========================================================
    // State
    logic cs_r, cs_nxt, we_r, we_nxt, oe_r, oe_nxt, ok_r, ok_nxt;
    logic rd_prev_r, rd_prev_nxt; // Read access seen last cycle
    logic [7:0] clk_r [16], clk_nxt [16]; // External set and controls
    logic [7:0] int_r [8], int_nxt [8]; // Internal counting set
    logic [31:0] sec_cnt_r, sec_cnt_nxt; // One-second divider
    logic [31:0] unit_cnt_r, unit_cnt_nxt; // Watchdog unit divider
    logic [10:0] wd_left_r, wd_left_nxt; // Watchdog units remaining
    logic [31:0] por_cnt_r, por_cnt_nxt; // Reset hold counter
    logic bat_r, bat_nxt; // Backup source engaged
    logic [7:0] dout_r, dout_nxt;
    logic doe_r, doe_nxt;
    logic irq_r, irq_nxt, rst_r, rst_nxt;
    logic [7:0] mem [MEM_BYTES]; // Plain storage below the clock page

    // Calendar helpers
    function automatic logic [7:0] bcd_inc(input logic [7:0] v);
        bcd_inc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : v + 8'h01;
    endfunction

    function automatic logic [7:0] month_days(input logic [7:0] mon,
                                              input logic [7:0] yr);
        logic leap;
        leap = ({yr[4], 1'b0} + yr[1:0]) % 2'd3 == 2'd0 && !yr[0]
               && (yr[4] ? yr[1] : !yr[1]);
        case (mon)
            8'h02: month_days = leap ? 8'h29 : 8'h28;
            8'h04, 8'h06, 8'h09, 8'h11: month_days = 8'h30;
            default: month_days = 8'h31;
        endcase
    endfunction

    // ==========================================================
    // Next-state logic for bus, clock, alarm, watchdog and power
    always_comb begin
        logic [ADDR_W-1:0] a;
        logic [3:0] o;
        logic clk_page, wr, rd, tick, carry, match, hold;
        // Every local gets a value before any branch reads it
        {clk_page, wr, rd, tick, carry, match, hold} = '0;
        a = pin3_w.addr;
        o = a[3:0];
        clk_page = (a[ADDR_W-1:4] == CLK_PAGE);
        // Glitch filter: take a level once stages 2 and 3 agree
        cs_nxt = (pin2_w.cs_n == pin3_w.cs_n) ? !pin3_w.cs_n : cs_r;
        we_nxt = (pin2_w.we_n == pin3_w.we_n) ? !pin3_w.we_n : we_r;
        oe_nxt = (pin2_w.oe_n == pin3_w.oe_n) ? !pin3_w.oe_n : oe_r;
        ok_nxt = (ok2_w == ok3_w) ? ok3_w : ok_r;
        wr = cs_r && we_r && ok_r;
        rd = cs_r && !we_r && ok_r;
        rd_prev_nxt = rd;
        clk_nxt = clk_r;
        int_nxt = int_r;
        // Read data path and pin drive
        dout_nxt = clk_page ? clk_r[o] : mem[a];
        doe_nxt = rd && oe_r;
        // Internal set counts on every second unless the OSC bit of register 9 is set, whatever the hold bits
        tick = (sec_cnt_r == 32'(SEC_CYC - 1)) && !clk_r[9][BIT_OSC];
        sec_cnt_nxt = (sec_cnt_r == 32'(SEC_CYC - 1)) ? '0 : sec_cnt_r + 1;
        carry = tick;
        if (carry) begin
            carry = (int_r[1] == 8'h59);
            int_nxt[1] = carry ? 8'h00 : bcd_inc(int_r[1]);
        end
        if (carry) begin
            carry = (int_r[2] == 8'h59);
            int_nxt[2] = carry ? 8'h00 : bcd_inc(int_r[2]);
        end
        if (carry) begin
            carry = (int_r[3] == 8'h23);
            int_nxt[3] = carry ? 8'h00 : bcd_inc(int_r[3]);
            if (carry) begin
                int_nxt[4] = (int_r[4] == 8'h07) ? 8'h01 : bcd_inc(int_r[4]);
            end
        end
        if (carry) begin
            carry = (int_r[5] >= month_days(int_r[6], int_r[7]));
            int_nxt[5] = carry ? 8'h01 : bcd_inc(int_r[5]);
        end
        if (carry) begin
            carry = (int_r[6] == 8'h12);
            int_nxt[6] = carry ? 8'h01 : bcd_inc(int_r[6]);
        end
        if (carry) begin
            carry = (int_r[7] == 8'h99);
            int_nxt[7] = carry ? 8'h00 : bcd_inc(int_r[7]);
            if (carry) begin
                int_nxt[0] = (int_r[0] == 8'h39) ? 8'h00 : bcd_inc(int_r[0]);
            end
        end
        // Copy to the external set unless the user holds it
        hold = clk_r[OFS_CTRL][BIT_W] || clk_r[OFS_CTRL][BIT_R];
        for (int i = 0; i < 8; i++) begin
            if (!hold) begin
                clk_nxt[8+i] = (clk_r[8+i] & ~TIME_MASK[i])
                               | (int_r[i] & TIME_MASK[i]);
            end
        end
        // Alarm compares the current time against programmed values
        match = 1'b1;
        for (int k = 0; k < 4; k++) begin
            if (!clk_r[OFS_ALM_SEC+k][BIT_AM] && clk_r[OFS_ALM_SEC+k][6:0]
                != int_r[(k == 3) ? 5 : k+1][6:0]) begin
                match = 1'b0;
            end
        end
        // Read of flags clears the event bits
        if (rd && !rd_prev_r && clk_page && o == OFS_FLAGS) begin
            clk_nxt[OFS_FLAGS][BIT_AF] = 1'b0;
            clk_nxt[OFS_FLAGS][BIT_WF] = 1'b0;
        end
        // Watchdog unit divider and countdown
        unit_cnt_nxt = (unit_cnt_r == 32'(WD_UNIT_CYC - 1)) ? '0
                       : unit_cnt_r + 1;
        wd_left_nxt = wd_left_r;
        por_cnt_nxt = (por_cnt_r != 0) ? por_cnt_r - 1 : por_cnt_r;
        if (unit_cnt_r == 32'(WD_UNIT_CYC - 1) && wd_left_r != 0) begin
            wd_left_nxt = wd_left_r - 11'd1;
            if (wd_left_r == 11'd1) begin
                wd_left_nxt = 11'({clk_r[OFS_WDOG][6:2], 6'b0}
                                  >> (6 - 2 * clk_r[OFS_WDOG][1:0]));
                clk_nxt[OFS_FLAGS][BIT_WF] = 1'b1;
                if (clk_r[OFS_WDOG][BIT_WDS]) begin
                    por_cnt_nxt = 32'(POR_CYC);
                end
            end
        end
        // Host write, same cycle for memory and clock page
        if (wr && clk_page) begin
            if (o == OFS_WDOG) begin
                wd_left_nxt = 11'({pin3_w.data[6:2], 6'b0}
                                  >> (6 - 2 * pin3_w.data[1:0]));
                unit_cnt_nxt = '0;
            end
            if (o == OFS_CTRL && clk_r[o][BIT_W]
                && !pin3_w.data[BIT_W]) begin
                for (int i = 0; i < 8; i++) begin
                    int_nxt[i] = (i == 0 ? clk_r[8] : clk_r[8+i])
                                 & TIME_MASK[i];
                end
                sec_cnt_nxt = '0;
            end
            if (o != OFS_FLAGS) begin
                clk_nxt[o] = pin3_w.data;
            end
        end
        // Event sets win over any clear in the same cycle
        if (tick && match) begin
            clk_nxt[OFS_FLAGS][BIT_AF] = 1'b1;
        end
        clk_nxt[OFS_FLAGS][BIT_BAT_LOW] = s3_r[0];
        // Interrupt pin: alarm on battery only when enabled
        irq_nxt = (clk_r[OFS_FLAGS][BIT_AF] && clk_r[OFS_INTR][BIT_AE]
                   && (ok_r || clk_r[OFS_INTR][BIT_ABE]))
                  || (clk_r[OFS_FLAGS][BIT_WF] && !clk_r[OFS_WDOG][BIT_WDS]);
        // Power-fail reset and its hold after recovery
        if (!ok_r) begin
            por_cnt_nxt = 32'(POR_CYC);
        end
        rst_nxt = !ok_r || (por_cnt_r != 0);
        bat_nxt = bat_r || ok_r;
    end

    // Register all state except the memory array
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            {cs_r, we_r, oe_r, ok_r, rd_prev_r} <= '0;
            for (int i = 0; i < 16; i++) begin
                clk_r[i] <= (i == OFS_DATE || i == OFS_MONTH
                             || i == OFS_DAY) ? DATE_RST : REG_RST;
            end
            for (int i = 0; i < 8; i++) begin
                int_r[i] <= (i >= 4 && i <= 6) ? DATE_RST : REG_RST;
            end
            {sec_cnt_r, unit_cnt_r} <= '0;
            wd_left_r <= '0;
            por_cnt_r <= 32'(POR_CYC);
            bat_r <= 1'b0;
            dout_r <= '0;
            doe_r <= 1'b0;
            irq_r <= 1'b0;
            rst_r <= 1'b1;
        end else begin
            {cs_r, we_r, oe_r, ok_r, rd_prev_r} <=
                {cs_nxt, we_nxt, oe_nxt, ok_nxt, rd_prev_nxt};
            clk_r <= clk_nxt;
            int_r <= int_nxt;
            {sec_cnt_r, unit_cnt_r} <= {sec_cnt_nxt, unit_cnt_nxt};
            wd_left_r <= wd_left_nxt;
            por_cnt_r <= por_cnt_nxt;
            bat_r <= bat_nxt;
            dout_r <= dout_nxt;
            doe_r <= doe_nxt;
            irq_r <= irq_nxt;
            rst_r <= rst_nxt;
        end
    end

    // Memory array write, below the clock page only
    always_ff @(posedge mclk) begin
        if (!sys_rst && cs_r && we_r && ok_r
            && pin3_w.addr[ADDR_W-1:4] != CLK_PAGE) begin
            mem[pin3_w.addr] <= pin3_w.data;
        end
    end

    // ==========================================================
    // Outputs
    assign data_out = dout_r;
    assign data_oe = doe_r;
    assign alarm_interrupt_out_n = !irq_r;
    assign alarm_interrupt_oe = irq_r;
    assign reset_out_n = !rst_r;
    assign reset_oe = rst_r;
    assign battery_connected = bat_r;
    assign on_battery = bat_r && !s3_r[1];

    // ==========================================================
    // Checks
    AST_FLOAT_DESEL: assert property (@(posedge mclk) disable iff (sys_rst)
        !cs_r |=> !data_oe) else $error("data driven while deselected");
    AST_READ_OE: assert property (@(posedge mclk) disable iff (sys_rst)
        cs_r && !we_r && oe_r && ok_r |=> data_oe)
        else $error("read not driven");
    AST_NO_DRIVE_WR: assert property (@(posedge mclk) disable iff (sys_rst)
        we_r |=> !data_oe) else $error("data driven during write");
    AST_FAIL_DESEL: assert property (@(posedge mclk) disable iff (sys_rst)
        !ok_r |=> !data_oe) else $error("access during power fail");
    AST_RST_FAIL: assert property (@(posedge mclk) disable iff (sys_rst)
        !ok_r |=> !reset_out_n) else $error("reset not held");
    AST_RST_HOLD: assert property (@(posedge mclk) disable iff (sys_rst)
        $rose(ok_r) |=> !reset_out_n [*8]) else $error("short hold");
    AST_BAT_ON: assert property (@(posedge mclk) disable iff (sys_rst)
        ok_r |=> battery_connected) else $error("battery not engaged");
    AST_BAT_KEEP: assert property (@(posedge mclk) disable iff (sys_rst)
        battery_connected |=> battery_connected)
        else $error("battery dropped");
    AST_BAT_LOW_FLAG: assert property (@(posedge mclk) disable iff (sys_rst)
        ##1 clk_r[OFS_FLAGS][BIT_BAT_LOW] == $past(s3_r[0]))
        else $error("battery flag wrong");
    AST_ALARM_BAT: assert property (@(posedge mclk) disable iff (sys_rst)
        !ok_r && !clk_r[OFS_INTR][BIT_ABE] && !clk_r[OFS_FLAGS][BIT_WF]
        |=> alarm_interrupt_out_n) else $error("alarm on battery");
    AST_SEC_RANGE: assert property (@(posedge mclk) disable iff (sys_rst)
        int_r[1][3:0] <= 4'h9 |=> int_r[1] <= 8'h59)
        else $error("seconds out of range");
endmodule // nv_timekeeping_sram_rtc
`default_nettype wire

//--- sim/host_bus_model.sv
// Host side of the parallel memory port, as a bus controller would drive it.
// Assumes the bench clock; pins move on the falling edge only.
`timescale 1ns/1ps
`default_nettype none
module host_bus_model
    import rtc_pkg::*;
(
    // Clock
    input wire logic mclk,
    // Pins towards the device
    output logic [ADDR_W-1:0] address_in,
    output logic chip_sel_n,
    output logic write_en_n,
    output logic out_en_n,
    output logic [7:0] data_in,
    // Pins from the device
    input wire logic [7:0] data_out,
    input wire logic data_oe
);
    // ==========================================================
    // Idle: deselected, data lines held at the filler byte 8'hA5
    initial begin
        address_in = '0;
        chip_sel_n = 1'b1;
        write_en_n = 1'b1;
        out_en_n = 1'b1;
        data_in = 8'hA5;
    end

    // ==========================================================
    // Byte write: strobes low six edges, data kept one edge past release
    task automatic write_byte(input logic [ADDR_W-1:0] a,
        input logic [7:0] d);
        @(negedge mclk);
        address_in = a;
        data_in = d;
        chip_sel_n = 1'b0;
        write_en_n = 1'b0;
        repeat (6) @(negedge mclk);
        chip_sel_n = 1'b1;
        write_en_n = 1'b1;
        @(negedge mclk);
        // Released data lines show garbage, not the last byte
        data_in = ~d;
        repeat (3) @(negedge mclk);
    endtask

    // Byte read with selectable select and output enable levels
    task automatic read_byte(input logic [ADDR_W-1:0] a, input logic cs_n,
        input logic oe_n, output logic [7:0] d, output logic v);
        @(negedge mclk);
        address_in = a;
        chip_sel_n = cs_n;
        out_en_n = oe_n;
        repeat (7) @(negedge mclk);
        d = data_out;
        v = data_oe;
        chip_sel_n = 1'b1;
        out_en_n = 1'b1;
        repeat (4) @(negedge mclk);
    endtask
endmodule // host_bus_model
`default_nettype wire

//--- sim/testbench.sv
// Self-checking bench for the timekeeping memory block.
// Assumes the package and the host bus model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import rtc_pkg::*;
    // Shortened counts handed to the design
    localparam longint SEC = 50;
    localparam longint POR = 20;
    localparam longint WDU = 10;
    // ==========================================================
    // Signals
    logic mclk, sys_rst, pf_ok, bsl_ok, bat_exh;
    logic [ADDR_W-1:0] address_in;
    logic chip_sel_n, write_en_n, out_en_n;
    logic [7:0] data_in, data_out;
    logic data_oe, on_battery, battery_connected;
    logic irq_n, irq_oe, rst_n, rst_oe, irq_wire, rst_wire;
    int fails = 0;
    int check_count = 0;
    // Open-drain pins with pull-ups
    assign irq_wire = irq_oe ? irq_n : 1'b1;
    assign rst_wire = rst_oe ? rst_n : 1'b1;

    // ==========================================================
    // Clock, instances
    initial mclk = 1'b0;
    always #5 mclk = ~mclk;
    host_bus_model host_bus_model_i (.mclk(mclk), .address_in(address_in),
        .chip_sel_n(chip_sel_n), .write_en_n(write_en_n),
        .out_en_n(out_en_n), .data_in(data_in), .data_out(data_out),
        .data_oe(data_oe));
    nv_timekeeping_sram_rtc #(.SEC_CYC(SEC), .POR_CYC(POR),
        .WD_UNIT_CYC(WDU)) nv_timekeeping_sram_rtc_i (.mclk(mclk),
        .sys_rst(sys_rst), .address_in(address_in), .chip_sel_n(chip_sel_n),
        .write_en_n(write_en_n), .out_en_n(out_en_n), .data_in(data_in),
        .data_out(data_out), .data_oe(data_oe),
        .above_power_fail_trip_level(pf_ok),
        .above_battery_switch_level(bsl_ok), .battery_exhausted(bat_exh),
        .on_battery(on_battery), .battery_connected(battery_connected),
        .alarm_interrupt_out_n(irq_n), .alarm_interrupt_oe(irq_oe),
        .reset_out_n(rst_n), .reset_oe(rst_oe));

    // ==========================================================
    // Helpers
    task automatic check(input string what, input logic [31:0] seen,
        input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [3:0] o, input logic [7:0] d);
        host_bus_model_i.write_byte({CLK_PAGE, o}, d);
    endtask
    task automatic rd(input logic [3:0] o, output logic [7:0] d);
        logic v;
        host_bus_model_i.read_byte({CLK_PAGE, o}, 1'b0, 1'b0, d, v);
    endtask
    // Wait for interrupt (s=0) or reset (s=1) pin to reach a level
    task automatic await(input int s, input logic lvl, output int n);
        n = 0;
        while ((s ? rst_wire : irq_wire) !== lvl && n < 300) begin
            @(negedge mclk);
            n++;
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // ==========================================================
    // Hang guard
    initial begin
        repeat (20000) @(posedge mclk);
        fails++;
        $display("MISMATCH run expected end seen hang");
        print_verdict();
    end

    // ==========================================================
    // Test sequence
    initial begin
        logic [7:0] d;
        logic v;
        int n;
        logic [ADDR_W-1:0] ma [3] = '{15'h0000, 15'h0010, 15'h7FEF};
        logic [7:0] md [3] = '{8'h5A, 8'h3C, 8'hC3};
        logic [7:0] yr [2] = '{8'h23, 8'h24};
        logic [7:0] ed [2] = '{8'h01, 8'h29};
        logic [7:0] em [2] = '{8'h03, 8'h02};
        sys_rst = 1'b1;
        pf_ok = 1'b0;
        bsl_ok = 1'b0;
        bat_exh = 1'b0;
        repeat (16) @(negedge mclk);
        sys_rst = 1'b0;
        repeat (10) @(negedge mclk);
        check("battery_connected", battery_connected, 0);
        check("reset_pin", rst_wire, 0);
        pf_ok = 1'b1;
        bsl_ok = 1'b1;
        await(1, 1'b1, n);
        check("por_hold", n >= POR && n <= POR + 8, 1);
        check("battery_connected", battery_connected, 1);
        $display("test power_on done");
        // Memory bytes and clock page through identical cycles
        foreach (ma[i]) host_bus_model_i.write_byte(ma[i], md[i]);
        foreach (ma[i]) begin
            host_bus_model_i.read_byte(ma[i], 1'b0, 1'b0, d, v);
            check("mem_data", d, md[i]);
            check("mem_drive", v, 1);
        end
        rd(OFS_DATE, d);
        check("date_reset", d, DATE_RST);
        host_bus_model_i.read_byte(ma[1], 1'b1, 1'b0, d, v);
        check("deselect_float", v, 0);
        host_bus_model_i.read_byte(ma[1], 1'b0, 1'b1, d, v);
        check("no_oe_float", v, 0);
        $display("test memory done");
        // Battery-low flag is read only
        rd(OFS_FLAGS, d);
        check("bat_low_clear", d[BIT_BAT_LOW], 0);
        bat_exh = 1'b1;
        wr(OFS_FLAGS, 8'h00);
        rd(OFS_FLAGS, d);
        check("bat_low_set", d[BIT_BAT_LOW], 1);
        bat_exh = 1'b0;
        $display("test battery_flag done");
        // Midnight rollover of end of February, plain and leap year
        foreach (yr[k]) begin
            wr(OFS_CTRL, 8'hA0);
            wr(4'h9, 8'h59);
            wr(4'hA, 8'h59);
            wr(4'hB, 8'h23);
            wr(OFS_DATE, 8'h28);
            wr(OFS_MONTH, 8'h02);
            wr(OFS_YEAR, yr[k]);
            wr(OFS_CTRL, 8'h20);
            repeat (60) @(negedge mclk);
            wr(OFS_CTRL, 8'h60);
            rd(4'h9, d);
            check("seconds", d, 8'h00);
            rd(4'hA, d);
            check("minutes", d, 8'h00);
            rd(4'hB, d);
            check("hours", d, 8'h00);
            rd(OFS_DATE, d);
            check("date", d, ed[k]);
            rd(OFS_MONTH, d);
            check("month", d, em[k]);
            rd(OFS_CTRL, d);
            check("century", d & 8'h3F, 8'h20);
            repeat (120) @(negedge mclk);
            rd(4'h9, d);
            check("frozen_seconds", d, 8'h00);
            wr(OFS_CTRL, 8'h20);
            repeat (20) @(negedge mclk);
            wr(OFS_CTRL, 8'h60);
            rd(4'h9, d);
            check("kept_counting", d > 8'h02, 1);
        end
        $display("test calendar done");
        // Alarm on seconds match, other fields ignored
        wr(OFS_CTRL, 8'hA0);
        wr(4'h9, 8'h00);
        wr(OFS_ALM_SEC, 8'h01);
        for (int o = 3; o < 6; o++) wr(o[3:0], 8'h80);
        rd(OFS_FLAGS, d);
        wr(OFS_INTR, 8'h80);
        wr(OFS_CTRL, 8'h20);
        check("irq_idle", irq_wire, 1);
        await(0, 1'b0, n);
        check("irq_alarm", irq_wire, 0);
        rd(OFS_FLAGS, d);
        rd(OFS_FLAGS, d);
        check("alarm_flag_cleared", d[BIT_AF], 0);
        check("irq_released", irq_wire, 1);
        wr(OFS_INTR, 8'h00);
        $display("test alarm done");
        // Watchdog left unserviced, interrupt then reset steering
        wr(OFS_WDOG, 8'h04);
        await(0, 1'b0, n);
        check("wdog_irq", irq_wire, 0);
        wr(OFS_WDOG, 8'h84);
        await(1, 1'b0, n);
        check("wdog_rst", rst_wire, 0);
        wr(OFS_WDOG, 8'h00);
        rd(OFS_FLAGS, d);
        repeat (40) @(negedge mclk);
        check("wdog_off_rst", rst_wire, 1);
        check("wdog_off_irq", irq_wire, 1);
        $display("test watchdog done");
        // Supply failure: deselected, host held, battery takes over
        pf_ok = 1'b0;
        bsl_ok = 1'b0;
        repeat (10) @(negedge mclk);
        check("fail_reset", rst_wire, 0);
        check("on_battery", on_battery, 1);
        host_bus_model_i.write_byte(ma[1], 8'hA5);
        host_bus_model_i.read_byte(ma[1], 1'b0, 1'b0, d, v);
        check("fail_float", v, 0);
        pf_ok = 1'b1;
        bsl_ok = 1'b1;
        await(1, 1'b1, n);
        check("recover_hold", n >= POR && n <= POR + 8, 1);
        host_bus_model_i.read_byte(ma[1], 1'b0, 1'b0, d, v);
        check("write_blocked", d, md[1]);
        $display("test power_fail done");
        print_verdict();
    end
endmodule // testbench
`default_nettype wire
